// [hw/branch_condition_eval.sv]
// condition evaluator for relative branch opcodes
`timescale 1ns/1ps
`default_nettype none
module branch_condition_eval
(
    cond_if.eval cif
);
    logic c;
    logic v;
    logic z;
    logic n;
    assign c = cif.flags[branch_pkg::FLAG_C];
    assign v = cif.flags[branch_pkg::FLAG_V];
    assign z = cif.flags[branch_pkg::FLAG_Z];
    assign n = cif.flags[branch_pkg::FLAG_N];
    assign cif.is_branch = (cif.opcode[7:4] == 4'h2);

    always_comb
    begin
        case (cif.opcode)
            branch_pkg::OP_ALWAYS:      cif.taken = 1'b1;
            branch_pkg::OP_NEVER:       cif.taken = 1'b0;
            branch_pkg::OP_U_ABOVE:     cif.taken = ~(c | z);
            branch_pkg::OP_U_AT_MOST:   cif.taken = c | z;
            branch_pkg::OP_CARRY_CLEAR: cif.taken = ~c;
            // below and carry-set share one opcode
            branch_pkg::OP_CARRY_SET:   cif.taken = c;
            branch_pkg::OP_NOT_EQUAL:   cif.taken = ~z;
            branch_pkg::OP_EQUAL:       cif.taken = z;
            branch_pkg::OP_OVF_CLEAR:   cif.taken = ~v;
            branch_pkg::OP_OVF_SET:     cif.taken = v;
            branch_pkg::OP_POSITIVE:    cif.taken = ~n;
            branch_pkg::OP_NEGATIVE:    cif.taken = n;
            branch_pkg::OP_S_AT_LEAST:  cif.taken = ~(n ^ v);
            branch_pkg::OP_S_BELOW:     cif.taken = n ^ v;
            branch_pkg::OP_S_ABOVE:     cif.taken = ~(z | (n ^ v));
            branch_pkg::OP_S_AT_MOST:   cif.taken = z | (n ^ v);
            default:                    cif.taken = 1'b0;
        endcase
    end
endmodule // branch_condition_eval
`default_nettype wire

// [hw/relative_branch_condition_unit.sv]
// sequencer for relative branches: fetch, offset with pc update, dummy read
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - taken: new pc is opcode address+2+offset
// - 2F taken when Z or (N xor V)
// - 25 taken when carry set
// - below and carry-set are one opcode
// - three reads: opcode, offset, dummy FFFF
// - 2B, 2A, 29, 28 single flag tests
// - 27 on Z set, 26 on Z clear
// - 20 always, 21 never, full cycles
// - non-arithmetic ops keep carry unchanged
module relative_branch_condition_unit
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  rd_data,
    input  wire logic        flags_load,
    input  wire logic [7:0]  flags_in,
    input  wire logic        carry_keep,
    output logic      [15:0] addr,
    output logic             rw,
    output logic             bus_cycle,
    output logic      [15:0] pc,
    output logic      [7:0]  condition_flags_reg,
    output logic             branch_taken,
    output logic             illegal_op
);
    // ==========================================
    // condition evaluator, reached over the condition interface
    cond_if cif ();
    branch_condition_eval u_eval (.cif(cif));

    // ==========================================
    // state and next values
    branch_pkg::seq_state_e state;
    branch_pkg::seq_state_e next_state;
    logic [7:0]  opcode;
    logic [7:0]  next_opcode;
    logic [15:0] next_pc;
    logic [7:0]  next_flags;
    logic        next_taken;
    logic        next_illegal;
    logic [15:0] offset_ext;
    logic        fetch_is_branch;
    logic [15:0] fall_pc;
    logic [15:0] target_pc;

    // ==========================================
    // evaluator hookup and fetched byte decode
    assign cif.opcode = opcode;
    assign cif.flags  = condition_flags_reg;
    // offset is taken straight from the bus in the offset cycle
    assign offset_ext = {{8{rd_data[7]}}, rd_data};
    // the top nibble alone marks the relative branch group
    assign fetch_is_branch = (rd_data[7:4] == 4'h2);

    // ==========================================
    // branch target arithmetic
    assign fall_pc   = pc + branch_pkg::PC_STEP;
    assign target_pc = fall_pc + offset_ext;

    // ==========================================
    // bus side
    // every cycle is a read; this unit never writes memory
    assign rw        = 1'b1;
    assign bus_cycle = 1'b1;

    // ==========================================
    // address mux
    // the dummy read parks the bus on the top address after pc has taken its new value
    always_comb
    begin
        case (state)
            branch_pkg::ST_FETCH:  addr = pc;
            branch_pkg::ST_OFFSET: addr = pc + 16'h0001;
            branch_pkg::ST_DUMMY:  addr = branch_pkg::DUMMY_ADDR;
            default:               addr = pc;
        endcase
    end

    // ==========================================
    // sequencer next state
    always_comb
    begin
        next_state   = state;
        next_opcode  = opcode;
        next_pc      = pc;
        case (state)
            branch_pkg::ST_FETCH:
            begin
                next_opcode  = rd_data;
                // non-branch opcodes are skipped one byte; other classes live elsewhere
                if (fetch_is_branch)
                begin
                    next_state = branch_pkg::ST_OFFSET;
                end
                else
                begin
                    next_pc = pc + 16'h0001;
                end
            end
            branch_pkg::ST_OFFSET:
            begin
                next_state = branch_pkg::ST_DUMMY;
                if (cif.taken && cif.is_branch)
                begin
                    next_pc = target_pc;
                end
                else
                begin
                    next_pc = fall_pc;
                end
            end
            branch_pkg::ST_DUMMY:
            begin
                // the new pc is already in place for the next fetch
                next_state = branch_pkg::ST_FETCH;
            end
            default:
            begin
                next_state = branch_pkg::ST_FETCH;
            end
        endcase
    end

    // ==========================================
    // branch result and decode status next values
    always_comb
    begin
        next_taken   = branch_taken;
        next_illegal = illegal_op;
        case (state)
            branch_pkg::ST_FETCH:
            begin
                next_illegal = ~fetch_is_branch;
            end
            branch_pkg::ST_OFFSET:
            begin
                // held until the next branch decides, so the last outcome stays visible
                next_taken = cif.taken;
            end
            branch_pkg::ST_DUMMY:
            begin
                next_taken = branch_taken;
            end
            default:
            begin
                next_illegal = illegal_op;
            end
        endcase
    end

    // ==========================================
    // flags next value
    // a load is honoured only in the fetch cycle, so a branch in flight
    // always sees, and leaves, the flags in place at the end of its fetch cycle
    always_comb
    begin
        next_flags = condition_flags_reg;
        if (flags_load && state == branch_pkg::ST_FETCH)
        begin
            next_flags = flags_in;
            // spare-carry instructions hand the old carry back
            if (carry_keep)
            begin
                next_flags[branch_pkg::FLAG_C] = condition_flags_reg[branch_pkg::FLAG_C];
            end
        end
    end

    // ==========================================
    // sequencer registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state  <= branch_pkg::ST_FETCH;
            opcode <= 8'h00;
            pc     <= branch_pkg::PC_RESET;
        end
        else
        begin
            state  <= next_state;
            opcode <= next_opcode;
            pc     <= next_pc;
        end
    end

    // ==========================================
    // flags register
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            condition_flags_reg <= branch_pkg::FLAGS_RESET;
        end
        else
        begin
            condition_flags_reg <= next_flags;
        end
    end

    // ==========================================
    // result registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            branch_taken <= 1'b0;
            illegal_op   <= 1'b0;
        end
        else
        begin
            branch_taken <= next_taken;
            illegal_op   <= next_illegal;
        end
    end
endmodule // relative_branch_condition_unit
`default_nettype wire

// [inc/branch_pkg.sv]
// constants for the relative branch condition unit
package branch_pkg;
    localparam logic [7:0]  OP_ALWAYS       = 8'h20;
    localparam logic [7:0]  OP_NEVER        = 8'h21;
    localparam logic [7:0]  OP_U_ABOVE      = 8'h22;
    localparam logic [7:0]  OP_U_AT_MOST    = 8'h23;
    localparam logic [7:0]  OP_CARRY_CLEAR  = 8'h24;
    localparam logic [7:0]  OP_CARRY_SET    = 8'h25;
    localparam logic [7:0]  OP_NOT_EQUAL    = 8'h26;
    localparam logic [7:0]  OP_EQUAL        = 8'h27;
    localparam logic [7:0]  OP_OVF_CLEAR    = 8'h28;
    localparam logic [7:0]  OP_OVF_SET      = 8'h29;
    localparam logic [7:0]  OP_POSITIVE     = 8'h2A;
    localparam logic [7:0]  OP_NEGATIVE     = 8'h2B;
    localparam logic [7:0]  OP_S_AT_LEAST   = 8'h2C;
    localparam logic [7:0]  OP_S_BELOW      = 8'h2D;
    localparam logic [7:0]  OP_S_ABOVE      = 8'h2E;
    localparam logic [7:0]  OP_S_AT_MOST    = 8'h2F;
    localparam logic [15:0] DUMMY_ADDR      = 16'hFFFF;
    localparam logic [15:0] PC_STEP         = 16'h0002;
    localparam logic [15:0] PC_RESET        = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET     = 8'hD0;
    // flag positions in the condition flags register
    localparam int          FLAG_C          = 0;
    localparam int          FLAG_V          = 1;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_N          = 3;
    typedef enum logic [1:0] {
        ST_FETCH  = 2'b00,
        ST_OFFSET = 2'b01,
        ST_DUMMY  = 2'b11
    } seq_state_e;
endpackage

// [inc/cond_if.sv]
// interface between the sequencer and the condition evaluator
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
    logic [7:0] opcode;
    logic [7:0] flags;
    logic       is_branch;
    logic       taken;
    modport eval (input opcode, input flags, output is_branch, output taken);
    modport seq  (output opcode, output flags, input is_branch, input taken);
endinterface
`default_nettype wire

// [verification/branch_unit_sva.sv]
// port assertions for the relative branch unit
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module branch_unit_sva
(
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic [7:0]  rd_data,
    input wire logic        flags_load,
    input wire logic [7:0]  flags_in,
    input wire logic        carry_keep,
    input wire logic [15:0] addr,
    input wire logic        rw,
    input wire logic        bus_cycle,
    input wire logic [15:0] pc,
    input wire logic [7:0]  condition_flags_reg,
    input wire logic        branch_taken,
    input wire logic        illegal_op
);
    // fetch is seen as addr on pc; the stimulus keeps pc clear of the dummy address
    wire logic       fetch = (addr == pc) && (addr != 16'hFFFF);
    wire logic       br    = fetch && (rd_data[7:4] == 4'h2);
    wire logic [7:0] fl    = condition_flags_reg;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    chk_three_reads: assert property (br |=> (addr == $past(pc) + 16'h0001) ##1 (addr == 16'hFFFF))
        else $error("bad branch bus order");
    chk_read_only: assert property (rw && bus_cycle)
        else $error("not a read cycle");
    chk_branch_target: assert property (br |=> ##1 pc == $past(pc, 2) + 16'h0002
        + (branch_taken ? {{8{$past(rd_data[7])}}, $past(rd_data)} : 16'h0000)) else $error("bad target");
    chk_flags_kept: assert property (br |=> ##1 $stable(condition_flags_reg) [*2])
        else $error("flags moved in branch");
    chk_flag_load: assert property (fetch && flags_load && !carry_keep |=> fl == $past(flags_in))
        else $error("flags not loaded");
    chk_carry_kept: assert property (fetch && flags_load && carry_keep |=>
        fl[0] == $past(fl[0]) && fl[7:1] == $past(flags_in[7:1])) else $error("carry not kept");
    chk_at_most_cond: assert property (fetch && rd_data == branch_pkg::OP_S_AT_MOST |=>
        ##1 branch_taken == (fl[2] | (fl[3] ^ fl[1]))) else $error("bad signed at most");
    chk_below_cond: assert property (fetch && rd_data == branch_pkg::OP_CARRY_SET |=>
        ##1 branch_taken == fl[0]) else $error("bad unsigned below");
    chk_branch_legal: assert property (br |=> !illegal_op)
        else $error("branch flagged illegal");
    chk_other_skipped: assert property (fetch && rd_data[7:4] != 4'h2 |=> illegal_op && pc == $past(pc) + 16'h0001)
        else $error("other opcode not skipped");
endmodule // branch_unit_sva
bind relative_branch_condition_unit branch_unit_sva i_sva (.mclk, .reset_n, .rd_data, .flags_load,
    .flags_in, .carry_keep, .addr, .rw, .bus_cycle, .pc, .condition_flags_reg, .branch_taken, .illegal_op);
`default_nettype wire

// [verification/prog_mem_model.sv]
// program memory model on the far side of the branch unit
`timescale 1ns/1ps
`default_nettype none
// ====
// memory
module prog_mem_model
(
    input  wire logic        mclk,
    input  wire logic [15:0] addr,
    output logic      [7:0]  rd_data
);
    logic [7:0] mem [0:65535];
    logic [7:0] patt = 8'h5A;
    // dummy cycle data is junk, so it moves every cycle
    always @(posedge mclk) patt <= patt + 8'h37;
    assign rd_data = (addr == branch_pkg::DUMMY_ADDR) ? patt : mem[addr];
endmodule // prog_mem_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the relative branch unit
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module testbench;
    logic        mclk = 1'b0, reset_n = 1'b0, flags_load = 1'b0, carry_keep = 1'b0, branch_taken;
    logic [7:0]  flags_in = 8'h00, rd_data, condition_flags_reg, ef;
    logic [15:0] addr, pc, epc;
    logic        rw, bus_cycle, illegal_op;
    int          num_errors = 0, comparisons = 0, cycles = 0;
    relative_branch_condition_unit i_relative_branch_condition_unit (.mclk, .reset_n, .rd_data,
        .flags_load, .flags_in, .carry_keep, .addr, .rw, .bus_cycle, .pc, .condition_flags_reg,
        .branch_taken, .illegal_op);
    prog_mem_model i_prog_mem_model (.mclk, .addr, .rd_data);
    always #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 1000)
        begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end
    function automatic logic model(input logic [7:0] op, input logic [7:0] f);
        logic [7:0] cond;
        cond = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
        return cond[op[3:1]] ^ ~op[0];
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // entered at the edge that opens the fetch cycle
    task automatic run_one(input logic [7:0] op, input logic [7:0] rr, input logic pre);
        logic [7:0] f;
        logic [7:0] g;
        logic       k;
        logic       t;
        f = 8'($urandom);
        g = 8'($urandom);
        k = 1'($urandom);
        if (pre)
        begin
            // a byte outside the branch group is skipped with one fetch
            i_prog_mem_model.mem[epc] = {1'b1, 7'($urandom)};
            flags_load <= 1'b1;
            flags_in <= g;
            carry_keep <= ~k;
            @(posedge mclk);
            ef = k ? g : {g[7:1], ef[0]};
            epc = epc + 16'h0001;
        end
        i_prog_mem_model.mem[epc] = op;
        i_prog_mem_model.mem[epc + 16'h0001] = rr;
        flags_load <= 1'b1;
        flags_in <= f;
        carry_keep <= k;
        if (pre)
        begin
            #1;
            check(pc, epc, "skip pc");
            check(16'(illegal_op), 16'h0001, "illegal flag");
        end
        @(posedge mclk);
        flags_load <= 1'($urandom);
        flags_in <= 8'($urandom);
        ef = k ? {f[7:1], ef[0]} : f;
        t = model(op, ef);
        #1;
        check(addr, epc + 16'h0001, "offset addr");
        epc = epc + 16'h0002 + (t ? 16'($signed(rr)) : 16'h0000);
        @(posedge mclk);
        #1;
        check(pc, epc, "pc");
        check(16'(branch_taken), 16'(t), "taken");
        check(16'(condition_flags_reg), 16'(ef), "flags");
        check(16'(illegal_op), 16'h0000, "legal flag");
        check(addr, branch_pkg::DUMMY_ADDR, "dummy addr");
        check(16'({rw, bus_cycle}), 16'h0003, "read cycle");
        @(posedge mclk);
    endtask
    initial
    begin
        void'($urandom(32'h300b));
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        check(pc, 16'h0000, "reset pc");
        check(16'(condition_flags_reg), 16'h00D0, "reset flags");
        $display("reset test done");
        epc = 16'h0000;
        ef = 8'hD0;
        // low pc gets forward offsets only, so pc never wraps onto the dummy address
        for (int i = 0; i < 64; i++)
            run_one(8'h20 + 8'(i % 16), 8'($urandom) & ((epc < 16'h0200) ? 8'h7F : 8'hFF), i >= 32);
        $display("branch test done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
